// file: rtl/pmc_consts.vh
// Constants for the power mode and clock divider control block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// Register byte offsets
`define PMC_OFS_VRCTL 8'h00
`define PMC_OFS_LOOPCTL 8'h04
`define PMC_OFS_DIV 8'h08
`define PMC_OFS_LOCKCNT 8'h0C
`define PMC_OFS_MODE 8'h10
`define PMC_OFS_STATUS 8'h14

// Regulator control fields: [1:0] frequency field, [7:4] voltage step code
`define PMC_VR_REGULATOR_FREQUENCY_FIELD_LSB 0
`define PMC_VR_VSEL_LSB 4
`define PMC_VR_REGULATOR_FREQUENCY_FIELD_OFF 2'h0
`define PMC_VR_RESET 8'h81

// Loop control fields: [7:1] multiplier in half steps... [0] bypass
`define PMC_LC_BYPASS_BIT 0
`define PMC_LC_MULTIPLIER_SELECT_FIELD_LSB 1
`define PMC_LC_PDWN_BIT 8
`define PMC_MULTIPLIER_SELECT_FIELD_RESET 7'h14
`define PMC_MULTIPLIER_SELECT_FIELD_MIN 7'h01
`define PMC_MULTIPLIER_SELECT_FIELD_MAX 7'h7F

// Divider fields: [3:0] system select, [5:4] core select
`define PMC_DIV_SSEL_LSB 0
`define PMC_DIV_CSEL_LSB 4
`define PMC_SSEL_RESET 4'h5
`define PMC_CSEL_RESET 2'h0

// Lock counter reset value, in reference clock periods
`define PMC_LOCKCNT_RESET 16'h0200

// Mode command codes written to the mode register
`define PMC_CMD_NONE 3'h0
`define PMC_CMD_SLEEP 3'h1
`define PMC_CMD_DEEP 3'h2

// Longest settle time in microseconds
`define PMC_SETTLE_US 40

`endif

// file: rtl/pmc_clkdiv.v
// Programmable divider that produces a one-cycle enable pulse.
// Assumes the divisor is stable; a change takes effect within the current count.
`timescale 1ns/1ns

module pmc_clkdiv #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Control
	input wire run_i,
	input wire [WIDTH-1:0] div_i,
	// Output
	output reg tick_o
);

reg [WIDTH-1:0] count;

// Count to div-1 then pulse; a smaller divisor written mid-count wraps at once
always @(posedge clk_i) begin
	if (rst_i || !run_i) begin
		count <= {WIDTH{1'b0}};
		tick_o <= 1'b0;
	end else if (count + {{(WIDTH-1){1'b0}}, 1'b1} >= div_i) begin
		count <= {WIDTH{1'b0}};
		tick_o <= 1'b1;
	end else begin
		count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		tick_o <= 1'b0;
	end
end

endmodule // pmc_clkdiv

// file: rtl/pmc_top.v
// Power mode state machine, clock dividers and lock counter with a
// classic Wishbone register slave.
// Assumes clk_i stands for the loop output and ref_tick_i marks each
// reference clock period; reset_pin_i comes asynchronously from a pin.
// Register writes commit on the edge that samples ack high, so a master
// that abandons a cycle early leaves every register untouched.
// Multiplier codes are half steps over seven bits: 64x is out of reach.
// The divider and lock count choices are the software's; the logic
// only refuses a zero system select and a zero multiplier.
// The multiplier and voltage outputs follow their fields one cycle late.
`timescale 1ns/1ns
`include "pmc_consts.vh"

module pmc_top #(
	parameter CLK_MHZ = 50,
	parameter LOCK_W = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Reference and wake
	input wire ref_tick_i,
	input wire reset_pin_i,
	input wire wake_event_i,
	// Clock enables
	output wire core_clk_en_o,
	output wire sys_clk_en_o,
	// Loop and regulator
	output reg loop_bypass_o,
	output reg [6:0] loop_mult_o,
	output reg [3:0] core_volt_code_o,
	output reg regulator_on_o,
	output reg core_supply_on_o,
	// System side
	output reg async_access_allow_o,
	output reg pin_tristate_o,
	output reg boot_start_o,
	output reg [4:0] power_mode_o
);

// ------------------------------------------------------------
// Mode encoding
// ------------------------------------------------------------
localparam [4:0] ST_FULLON = 5'h01;
localparam [4:0] ST_ACTIVE = 5'h02;
localparam [4:0] ST_SLEEP = 5'h04;
localparam [4:0] ST_DEEP = 5'h08;
localparam [4:0] ST_HIBER = 5'h10;

// Regulator reset word: frequency field in the low bits, voltage code above
localparam [7:0] VR_RESET = `PMC_VR_RESET;

// ------------------------------------------------------------
// Pin synchronisers
// ------------------------------------------------------------
reg rst_pin_s1;
reg rst_pin_s2;
reg wake_s1;
reg wake_s2;

// Two flops before any logic sees the pins
// Only the second stage is read, so a metastable first stage stays local
always @(posedge clk_i) begin
	if (rst_i) begin
		rst_pin_s1 <= 1'b0;
		rst_pin_s2 <= 1'b0;
		wake_s1 <= 1'b0;
		wake_s2 <= 1'b0;
	end else begin
		rst_pin_s1 <= reset_pin_i;
		rst_pin_s2 <= rst_pin_s1;
		wake_s1 <= wake_event_i;
		wake_s2 <= wake_s1;
	end
end

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
reg [1:0] vr_regulator_frequency_field;
reg [3:0] vr_vsel;
reg lc_bypass;
reg lc_pdwn;
reg [6:0] lc_multiplier_select_field;
reg [3:0] ssel;
reg [1:0] csel;
reg [LOCK_W-1:0] lock_count;
reg [LOCK_W-1:0] lock_remain;
reg locking;
reg [2:0] mode_cmd;

// A request is new while ack is still low
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
// A write lands on the edge at which the master sees ack high
wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
wire wr_vr = wb_wr && (wb_adr_i == `PMC_OFS_VRCTL);
wire wr_lc = wb_wr && (wb_adr_i == `PMC_OFS_LOOPCTL);
wire wr_div = wb_wr && (wb_adr_i == `PMC_OFS_DIV);
wire wr_lock = wb_wr && (wb_adr_i == `PMC_OFS_LOCKCNT);
wire wr_mode = wb_wr && (wb_adr_i == `PMC_OFS_MODE);

wire [6:0] multiplier_select_field_wr = wb_dat_i[`PMC_LC_MULTIPLIER_SELECT_FIELD_LSB+6:`PMC_LC_MULTIPLIER_SELECT_FIELD_LSB];
wire [3:0] vsel_wr = wb_dat_i[`PMC_VR_VSEL_LSB+3:`PMC_VR_VSEL_LSB];
wire volt_chg = wr_vr && (vsel_wr != vr_vsel);
wire mult_chg = wr_lc && (multiplier_select_field_wr != lc_multiplier_select_field) && (multiplier_select_field_wr != 7'h00);

// Acknowledge one cycle after the request; drops the cycle after
// One wait state keeps the bus simple; no request is ever refused
always @(posedge clk_i) begin
	if (rst_i)
		wb_ack_o <= 1'b0;
	else
		wb_ack_o <= wb_req;
end

// Register writes; byte lane 0 carries most fields, lane 1 the power-down bit and the lock count high byte
always @(posedge clk_i) begin
	if (rst_i) begin
		vr_regulator_frequency_field <= VR_RESET[`PMC_VR_REGULATOR_FREQUENCY_FIELD_LSB+1:`PMC_VR_REGULATOR_FREQUENCY_FIELD_LSB];
		vr_vsel <= VR_RESET[`PMC_VR_VSEL_LSB+3:`PMC_VR_VSEL_LSB];
		lc_bypass <= 1'b0;
		lc_pdwn <= 1'b0;
		lc_multiplier_select_field <= `PMC_MULTIPLIER_SELECT_FIELD_RESET;
		ssel <= `PMC_SSEL_RESET;
		csel <= `PMC_CSEL_RESET;
		lock_count <= `PMC_LOCKCNT_RESET;
		mode_cmd <= `PMC_CMD_NONE;
	end else begin
		mode_cmd <= `PMC_CMD_NONE;
		if (wr_vr) begin
			vr_regulator_frequency_field <= wb_dat_i[`PMC_VR_REGULATOR_FREQUENCY_FIELD_LSB+1:`PMC_VR_REGULATOR_FREQUENCY_FIELD_LSB];
			vr_vsel <= vsel_wr;
		end
		// Waking from hibernate brings the regulator back; without this the
		// zero frequency field would send the mode straight back to hibernate
		if ((power_mode_o == ST_HIBER) && rst_pin_s2)
			vr_regulator_frequency_field <= VR_RESET[`PMC_VR_REGULATOR_FREQUENCY_FIELD_LSB+1:`PMC_VR_REGULATOR_FREQUENCY_FIELD_LSB];
		if (wr_lc) begin
			lc_bypass <= wb_dat_i[`PMC_LC_BYPASS_BIT];
			lc_pdwn <= wb_sel_i[1] & wb_dat_i[`PMC_LC_PDWN_BIT];
			if (multiplier_select_field_wr != 7'h00)
				lc_multiplier_select_field <= multiplier_select_field_wr;
		end
		if (wr_div) begin
			// Zero select is kept out; the divider would treat it as a divide by one
			if (wb_dat_i[`PMC_DIV_SSEL_LSB+3:`PMC_DIV_SSEL_LSB] != 4'h0)
				ssel <= wb_dat_i[`PMC_DIV_SSEL_LSB+3:`PMC_DIV_SSEL_LSB];
			csel <= wb_dat_i[`PMC_DIV_CSEL_LSB+1:`PMC_DIV_CSEL_LSB];
		end
		if (wr_lock)
			lock_count <= {wb_sel_i[1] ? wb_dat_i[15:8] : lock_count[15:8], wb_dat_i[7:0]};
		if (wr_mode)
			mode_cmd <= wb_dat_i[2:0];
	end
end

// Read mux; unmapped addresses read zero and still acknowledge
reg [31:0] rd_data;
always @* begin
	case (wb_adr_i)
	`PMC_OFS_VRCTL: rd_data = {24'h0, vr_vsel, 2'h0, vr_regulator_frequency_field};
	`PMC_OFS_LOOPCTL: rd_data = {23'h0, lc_pdwn, lc_multiplier_select_field, lc_bypass};
	`PMC_OFS_DIV: rd_data = {26'h0, csel, ssel};
	`PMC_OFS_LOCKCNT: rd_data = {{(32-LOCK_W){1'b0}}, lock_count};
	`PMC_OFS_MODE: rd_data = {27'h0, power_mode_o};
	`PMC_OFS_STATUS: rd_data = {15'h0, locking, lock_remain};
	default: rd_data = 32'h0;
	endcase
end

// Read data is registered so it stands until the next request
reg [31:0] rd_q;
always @(posedge clk_i) begin
	if (rst_i)
		rd_q <= 32'h0;
	else if (wb_req)
		rd_q <= rd_data;
end
assign wb_dat_o = rd_q;

// ------------------------------------------------------------
// Lock counter
// ------------------------------------------------------------
// Reloads on a multiplier or voltage change; decrements only on
// reference periods so the wait does not scale with the loop ratio
// A zero lock count skips the wait altogether
always @(posedge clk_i) begin
	if (rst_i) begin
		lock_remain <= {LOCK_W{1'b0}};
		locking <= 1'b0;
	end else if (mult_chg || volt_chg) begin
		lock_remain <= lock_count;
		locking <= (lock_count != {LOCK_W{1'b0}});
	end else if (locking && ref_tick_i) begin
		lock_remain <= lock_remain - {{(LOCK_W-1){1'b0}}, 1'b1};
		if (lock_remain == {{(LOCK_W-1){1'b0}}, 1'b1})
			locking <= 1'b0;
	end
end

// Applied multiplier and voltage follow the programmed values
always @(posedge clk_i) begin
	if (rst_i) begin
		loop_mult_o <= `PMC_MULTIPLIER_SELECT_FIELD_RESET;
		core_volt_code_o <= VR_RESET[`PMC_VR_VSEL_LSB+3:`PMC_VR_VSEL_LSB];
	end else begin
		loop_mult_o <= lc_multiplier_select_field;
		core_volt_code_o <= vr_vsel;
	end
end

// ------------------------------------------------------------
// Power mode state machine
// ------------------------------------------------------------
// Mode commands are honoured only from the two running modes; the
// asleep modes listen to their wake sources alone
reg [4:0] next_mode;
wire wake_mode_bypass = lc_bypass;
always @* begin
	next_mode = power_mode_o;
	case (power_mode_o)
	ST_FULLON, ST_ACTIVE: begin
		if (vr_regulator_frequency_field == `PMC_VR_REGULATOR_FREQUENCY_FIELD_OFF)
			next_mode = ST_HIBER;
		else if (mode_cmd == `PMC_CMD_DEEP)
			next_mode = ST_DEEP;
		else if (mode_cmd == `PMC_CMD_SLEEP)
			next_mode = ST_SLEEP;
		else if (!lc_bypass && !lc_pdwn)
			next_mode = ST_FULLON;
		else
			next_mode = ST_ACTIVE;
	end
	ST_SLEEP: begin
		// Any wake source ends sleep
		if (wake_s2 || rst_pin_s2)
			next_mode = wake_mode_bypass ? ST_ACTIVE : ST_FULLON;
	end
	ST_DEEP: begin
		// Other wake events are ignored here
		if (rst_pin_s2)
			next_mode = wake_mode_bypass ? ST_ACTIVE : ST_FULLON;
	end
	ST_HIBER: begin
		// Only the reset pin restores power
		if (rst_pin_s2)
			next_mode = ST_FULLON;
	end
	default: next_mode = ST_FULLON;
	endcase
end

// Mode register and the power-side outputs it drives
// Outputs follow next_mode so they change on the same edge as the mode
always @(posedge clk_i) begin
	if (rst_i) begin
		power_mode_o <= ST_FULLON;
		regulator_on_o <= 1'b1;
		core_supply_on_o <= 1'b1;
		pin_tristate_o <= 1'b0;
		async_access_allow_o <= 1'b1;
		boot_start_o <= 1'b0;
		loop_bypass_o <= 1'b0;
	end else begin
		power_mode_o <= next_mode;
		regulator_on_o <= (next_mode != ST_HIBER);
		core_supply_on_o <= (next_mode != ST_HIBER);
		pin_tristate_o <= (next_mode == ST_HIBER);
		async_access_allow_o <= (next_mode != ST_DEEP) && (next_mode != ST_HIBER);
		// Boot only once the regulator is back on
		boot_start_o <= (power_mode_o == ST_HIBER) && (next_mode != ST_HIBER);
		loop_bypass_o <= (next_mode == ST_ACTIVE);
	end
end

// ------------------------------------------------------------
// Clock dividers
// ------------------------------------------------------------
// Active mode bypasses the loop: both clocks run at the reference rate
wire in_bypass = (power_mode_o == ST_ACTIVE);
wire core_run = (power_mode_o == ST_FULLON) || in_bypass;
wire sys_run = core_run || (power_mode_o == ST_SLEEP);
wire [7:0] core_div = 8'h01 << csel;
wire [7:0] sys_div = {4'h0, ssel};
wire core_tick;
wire sys_tick;

// Each divider restarts from zero when its run condition returns
pmc_clkdiv #(.WIDTH(8)) u_core_div (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.run_i(core_run && !in_bypass),
	.div_i(core_div),
	.tick_o(core_tick)
);

pmc_clkdiv #(.WIDTH(8)) u_sys_div (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.run_i(sys_run && !in_bypass),
	.div_i(sys_div),
	.tick_o(sys_tick)
);

// Enables gated during relock so no glitchy loop clock leaks out
// Trade-off: enables are combinational so a tick costs no extra cycle
assign core_clk_en_o = core_run && !locking && (in_bypass ? ref_tick_i : core_tick);
assign sys_clk_en_o = sys_run && !locking && (in_bypass ? ref_tick_i : sys_tick);

endmodule // pmc_top

// file: testbench/pmc_props.sv
// Port checker for the power mode and clock divider block.
// Assumes the one-hot mode code and registered Wishbone ack.
`timescale 1ns/1ns
module pmc_props (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Watched ports
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire reset_pin_i,
	input wire core_clk_en_o,
	input wire sys_clk_en_o,
	input wire regulator_on_o,
	input wire core_supply_on_o,
	input wire async_access_allow_o,
	input wire pin_tristate_o,
	input wire boot_start_o,
	input wire [4:0] power_mode_o
);
	// --------------------------------------------------
	// Properties, all in the one clock domain
	// --------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_deep_clocks: assert property (power_mode_o == 5'h08 |-> !core_clk_en_o && !sys_clk_en_o)
		else $error("clock enable in deep sleep");
	a_deep_access: assert property (power_mode_o[3] || power_mode_o[4] |-> !async_access_allow_o)
		else $error("access allowed while asleep");
	a_deep_hold: assert property ((power_mode_o == 5'h08 && !reset_pin_i) [*3] |=> power_mode_o == 5'h08)
		else $error("deep sleep left without pin");
	a_hib_off: assert property (power_mode_o == 5'h10 |-> pin_tristate_o && !regulator_on_o
		&& !core_supply_on_o && !core_clk_en_o && !sys_clk_en_o)
		else $error("hibernate outputs wrong");
	a_sleep_core: assert property (power_mode_o == 5'h04 |-> !core_clk_en_o)
		else $error("core clock in sleep");
	a_mode_onehot: assert property ($onehot(power_mode_o))
		else $error("mode code not one-hot");
	a_boot_pulse: assert property (boot_start_o |-> regulator_on_o ##1 !boot_start_o)
		else $error("boot pulse wrong");
endmodule // pmc_props

bind pmc_top pmc_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .reset_pin_i(reset_pin_i),
	.core_clk_en_o(core_clk_en_o), .sys_clk_en_o(sys_clk_en_o),
	.regulator_on_o(regulator_on_o), .core_supply_on_o(core_supply_on_o),
	.async_access_allow_o(async_access_allow_o), .pin_tristate_o(pin_tristate_o),
	.boot_start_o(boot_start_o), .power_mode_o(power_mode_o));

// file: testbench/tb_top.sv
// Self-checking bench for the power mode and clock divider block.
// Assumes a reference tick every fourth clock, driven here.
`timescale 1ns/1ns
`include "pmc_consts.vh"
module tb_top;
	reg clk_i = 0, rst_i = 1, cyc = 0, we = 0, tick = 0, pin = 0, wake = 0;
	reg [7:0] adr = 8'h00;
	reg [31:0] wdat = 32'h0, rdat;
	reg [1:0] rc = 2'h0;
	wire [31:0] dat;
	wire ack, cen, sen, byp, reg_on, sup_on, acc, tri_st, boot;
	wire [6:0] mult;
	wire [3:0] volt;
	wire [4:0] mode;
	integer n_fail = 0, compares = 0, cycles = 0, cs, cc, c, k;
	pmc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
		.ref_tick_i(tick), .reset_pin_i(pin), .wake_event_i(wake), .core_clk_en_o(cen),
		.sys_clk_en_o(sen), .loop_bypass_o(byp), .loop_mult_o(mult), .core_volt_code_o(volt),
		.regulator_on_o(reg_on), .core_supply_on_o(sup_on), .async_access_allow_o(acc),
		.pin_tristate_o(tri_st), .boot_start_o(boot), .power_mode_o(mode));
	// Clock, reference tick and hang guard
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		rc <= rc + 2'h1;
		tick <= (rc == 2'h3);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			complete_run;
		end
	end
	// --------------------------------------------------
	// Shared tasks
	// --------------------------------------------------
	task complete_run;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("unexpected at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// Classic cycle: hold until ack is sampled, take data at that edge
	task wb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1;
			we <= w;
			adr <= a;
			wdat <= d;
			@(posedge clk_i);
			while (ack !== 1'b1)
				@(posedge clk_i);
			rdat = dat;
			cyc <= 0;
			we <= 0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			wb(0, a, 0);
			chk(rdat, e);
		end
	endtask
	// Counts enable pulses over n cycles; a slow divider shows fewer
	task cnt(input integer n);
		begin
			cs = 0;
			cc = 0;
			repeat (n) begin
				@(posedge clk_i);
				if (sen === 1'b1) cs = cs + 1;
				if (cen === 1'b1) cc = cc + 1;
			end
		end
	endtask
	task wait_mode(input [4:0] m);
		begin
			k = 0;
			while (mode !== m && k < 30) begin
				@(posedge clk_i);
				k = k + 1;
			end
			chk({27'h0, mode}, {27'h0, m});
		end
	endtask
	// --------------------------------------------------
	// Scenarios
	// --------------------------------------------------
	task t_reset;
		begin
			rd(`PMC_OFS_VRCTL, 32'h81);
			rd(`PMC_OFS_LOOPCTL, 32'h28);
			rd(`PMC_OFS_DIV, 32'h05);
			rd(`PMC_OFS_LOCKCNT, 32'h200);
			rd(`PMC_OFS_MODE, 32'h01);
			wb(1, 8'h20, 32'h55);
			rd(8'h20, 32'h0);
			$display("reset test done");
		end
	endtask
	task t_div;
		begin
			for (c = 0; c < 4; c = c + 1) begin
				wb(1, `PMC_OFS_DIV, (c << 4) | 6);
				repeat (8) @(posedge clk_i);
				cnt(120);
				chk(cs, 20);
				chk(cc, 120 >> c);
			end
			$display("divider test done");
		end
	endtask
	task t_lock;
		begin
			wb(1, `PMC_OFS_LOCKCNT, 32'h10);
			wb(1, `PMC_OFS_LOOPCTL, 32'h2C);
			repeat (2) @(posedge clk_i);
			chk({25'h0, mult}, 32'h16);
			wb(0, `PMC_OFS_STATUS, 0);
			chk({31'h0, rdat[16]}, 32'h1);
			cnt(40);
			chk(cs + cc, 0);
			repeat (60) @(posedge clk_i);
			rd(`PMC_OFS_STATUS, 32'h0);
			$display("lock test done");
		end
	endtask
	task t_sleep;
		begin
			wb(1, `PMC_OFS_MODE, 32'h1);
			wait_mode(5'h04);
			cnt(48);
			chk(cc, 0);
			chk(cs, 8);
			wake <= 1;
			wait_mode(5'h01);
			wake <= 0;
			$display("sleep test done");
		end
	endtask
	// Bypass set first, so each exit target is seen
	task t_deep;
		integer b;
		begin
			for (b = 1; b >= 0; b = b - 1) begin
				wb(1, `PMC_OFS_LOOPCTL, 32'h2C | b);
				wait_mode(b ? 5'h02 : 5'h01);
				chk({31'h0, byp}, b);
				wb(1, `PMC_OFS_MODE, 32'h2);
				wait_mode(5'h08);
				chk({31'h0, acc}, 32'h0);
				wake <= 1;
				repeat (10) @(posedge clk_i);
				chk({27'h0, mode}, 32'h08);
				wake <= 0;
				pin <= 1;
				wait_mode(b ? 5'h02 : 5'h01);
				pin <= 0;
				repeat (4) @(posedge clk_i);
			end
			// Power-down bit alone also leaves the loop out of the path
			wb(1, `PMC_OFS_LOOPCTL, 32'h12C);
			wait_mode(5'h02);
			chk({31'h0, byp}, 32'h1);
			cnt(40);
			chk(cs, 10);
			chk(cc, 10);
			wb(1, `PMC_OFS_LOOPCTL, 32'h2C);
			wait_mode(5'h01);
			$display("deep sleep test done");
		end
	endtask
	task t_hib;
		begin
			wb(1, `PMC_OFS_VRCTL, 32'hA1);
			repeat (2) @(posedge clk_i);
			chk({28'h0, volt}, 32'hA);
			repeat (80) @(posedge clk_i);
			wb(1, `PMC_OFS_VRCTL, 32'hA0);
			wait_mode(5'h10);
			chk({29'h0, tri_st, reg_on, sup_on}, 32'h4);
			pin <= 1;
			k = 0;
			while (boot !== 1'b1 && k < 30) begin
				@(posedge clk_i);
				k = k + 1;
			end
			chk({30'h0, boot, reg_on}, 32'h3);
			wait_mode(5'h01);
			pin <= 0;
			repeat (4) @(posedge clk_i);
			chk({27'h0, mode}, 32'h01);
			rd(`PMC_OFS_VRCTL, 32'hA1);
			$display("hibernate test done");
		end
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		t_reset;
		t_div;
		t_lock;
		t_sleep;
		t_deep;
		t_hib;
		complete_run;
	end
endmodule // tb_top
